/* File: rtl/uc2_core.sv */
// serial interface core: control registers, transmit queueing, receiver, interrupt request
// Overview of operation
// - control register two is readable and writable at any time
// - transmit-empty enable bit 7 routes the buffer empty flag to the interrupt
// - transmit-done enable bit 6 routes the transmission complete flag to the interrupt
// - receive-full enable bit 5 routes the receive full flag to the interrupt
// - line-quiet enable bit 4 routes the idle line flag to the interrupt
// - transmitter sends data characters only with tx_on bit 3 set, which claims the transmit pin
// - single-wire mode: direction bit chooses driving or receiving the shared pin
// - turning tx_on off then on queues one idle character
// - after tx_on clears, the pin is held until queued work finishes
// - receiver runs only with rx_on bit 2; otherwise its pin is released
// - loopback releases the receive pin even with the receiver on
// - writing standby bit 1 parks the receiver until a wakeup condition
// - wakeup is idle line when method is 0, marked msb when 1
// - hardware clears the standby bit on wakeup
// - writing break bit 1 then 0 queues one break character
// - break is 10/11 zero bits, 13/14 long; repeats while bit stays set
// - a second break may go out before software clears the bit
// - frame is start, 8 data bits lsb first, optional ninth, stop
// - loopback feeds the transmitter output to the receiver input, except single-wire receiving, which takes the shared pin
`timescale 1ns/100ps
`default_nettype none
module uc2_core (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    input wire logic txdIn,
    output logic txdOut,
    output logic txdOe_n,
    output logic txPinOwned,
    input wire logic rxdIn,
    output logic rxPinOwned,
    output logic irq
);
    import uc2_pkg::*;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} uc2_rx_state_t;

    uc2_wb_req_t req;
    uc2_ctrl_one_t ctrlOne_q;
    uc2_ctrl_two_t ctrlTwo_q;
    uc2_status_t status;
    logic [15:0] baud_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic access;
    logic wrCtrlOne;
    logic wrCtrlTwo;
    logic wrData;
    logic wrBaud;
    logic rdData;
    uc2_ctrl_two_t newTwo;

    // transmit side
    logic [UC2_WORD_W-1:0] txHold_q;
    logic txFull_q;
    logic idleQueued_q;
    logic breakQueued_q;
    logic txOwned_q;
    logic txBusy;
    logic txLine;
    logic launch;
    logic sendBreak;
    logic sendIdle;
    logic sendData;
    logic [UC2_FRAME_W-1:0] frame;
    logic [3:0] frameLen;
    logic singleWire;

    // receive side
    uc2_rx_state_t rxState_q;
    logic [15:0] rxCyc_q;
    logic [3:0] rxBit_q;
    logic [UC2_WORD_W-1:0] rxShift_q;
    logic [UC2_WORD_W-1:0] rxData_q;
    logic rxFull_q;
    logic rxLine;
    logic charDone;
    logic wakeMark;
    logic deliver;
    logic [15:0] idleCyc_q;
    logic [3:0] idleBits_q;
    logic idleSeen_q;
    logic idleHit;
    logic idleArmed_q;
    logic lineQuiet_q;
    logic wakeIdle;

    function automatic logic [3:0] char_bits(input logic len9);
        char_bits = len9 ? UC2_CHAR_BITS_LONG : UC2_CHAR_BITS_SHORT;
    endfunction

    function automatic logic [UC2_FRAME_W-1:0] level_frame(input logic lvl);
        level_frame = {UC2_FRAME_W{lvl}};
    endfunction

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

    // one wait state: every access is answered on the edge after it is seen
    assign access = req.cyc && req.stb && !ack_q;
    assign wrCtrlOne = access && req.we && req.sel[0] && (req.adr == UC2_ADDR_CTRL_ONE);
    assign wrCtrlTwo = access && req.we && req.sel[0] && (req.adr == UC2_ADDR_CTRL_TWO);
    assign wrData = access && req.we && req.sel[0] && (req.adr == UC2_ADDR_DATA);
    assign wrBaud = access && req.we && (req.adr == UC2_ADDR_BAUD);
    assign rdData = access && !req.we && (req.adr == UC2_ADDR_DATA);
    assign newTwo = uc2_ctrl_two_t'(req.dat[7:0]);

    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdat_q <= 32'h0000_0000;
        end else if (access && !req.we) begin
            unique case (req.adr)
                UC2_ADDR_CTRL_ONE: rdat_q <= {24'h00_0000, ctrlOne_q};
                UC2_ADDR_CTRL_TWO: rdat_q <= {24'h00_0000, ctrlTwo_q};
                UC2_ADDR_STATUS: rdat_q <= {24'h00_0000, status};
                UC2_ADDR_DATA: rdat_q <= {23'h00_0000, rxData_q};
                UC2_ADDR_BAUD: rdat_q <= {16'h0000, baud_q};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlOne_q <= uc2_ctrl_one_t'(UC2_CTRL_ONE_RESET);
        end else if (wrCtrlOne) begin
            ctrlOne_q <= uc2_ctrl_one_t'(req.dat[7:0]);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            baud_q <= UC2_BAUD_RESET;
        end else if (wrBaud) begin
            if (req.sel[0]) begin
                baud_q[7:0] <= req.dat[7:0];
            end
            if (req.sel[1]) begin
                baud_q[15:8] <= req.dat[15:8];
            end
        end
    end

    // standby bit: a software write wins over the hardware wakeup clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlTwo_q <= uc2_ctrl_two_t'(UC2_CTRL_TWO_RESET);
        end else begin
            if ((wakeMark || wakeIdle) && ctrlTwo_q.rxStandby) begin
                ctrlTwo_q.rxStandby <= 1'b0;
            end
            if (wrCtrlTwo) begin
                ctrlTwo_q <= newTwo;
            end
        end
    end

    // transmit queueing
    assign singleWire = ctrlOne_q.loopbackSelect && ctrlOne_q.rxSourceSelect;
    assign sendBreak = breakQueued_q || ctrlTwo_q.breakQueue;
    assign sendIdle = !sendBreak && idleQueued_q;
    assign sendData = !sendBreak && !idleQueued_q && txFull_q && ctrlTwo_q.txOn;
    assign launch = txOwned_q && !txBusy && (baud_q != 16'h0000)
        && (sendBreak || sendIdle || sendData);

    always_comb begin
        frame = level_frame(1'b1);
        frameLen = char_bits(ctrlOne_q.charLen9);
        if (sendBreak) begin
            frame = level_frame(1'b0);
            if (ctrlOne_q.longBreakSelect) begin
                frameLen = char_bits(ctrlOne_q.charLen9) + UC2_LONG_BREAK_EXTRA;
            end
        end else if (sendData) begin
            // start bit low, data lsb first, optional ninth, stop high
            if (ctrlOne_q.charLen9) begin
                frame = {3'b111, 1'b1, txHold_q, 1'b0};
            end else begin
                frame = {4'b1111, 1'b1, txHold_q[7:0], 1'b0};
            end
        end
    end

    // a break starts only from an idle shifter, so a bit raised during one frame and
    // still set when the next frame ends yields two breaks
    always_ff @(posedge mclk) begin
        if (srst) begin
            breakQueued_q <= 1'b0;
        end else if (wrCtrlTwo && newTwo.breakQueue && !ctrlTwo_q.breakQueue) begin
            breakQueued_q <= 1'b1;
        end else if (launch && sendBreak) begin
            breakQueued_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            idleQueued_q <= 1'b0;
        end else if (wrCtrlTwo && newTwo.txOn && !ctrlTwo_q.txOn) begin
            idleQueued_q <= 1'b1;
        end else if (launch && sendIdle) begin
            idleQueued_q <= 1'b0;
        end
    end

    // a write into a full holding buffer replaces the waiting character
    always_ff @(posedge mclk) begin
        if (srst) begin
            txFull_q <= 1'b0;
            txHold_q <= '0;
        end else if (wrData) begin
            txFull_q <= 1'b1;
            txHold_q <= req.dat[UC2_WORD_W-1:0];
        end else if (launch && sendData) begin
            txFull_q <= 1'b0;
        end
    end

    // pin stays claimed after tx_on drops until shifter and queues are empty
    always_ff @(posedge mclk) begin
        if (srst) begin
            txOwned_q <= 1'b0;
        end else begin
            // a frame launched on the release edge must still find the pin claimed
            txOwned_q <= ctrlTwo_q.txOn
                || (txOwned_q && (txBusy || launch || idleQueued_q || breakQueued_q));
        end
    end

    uc2_tx_shift txShift (
        .mclk(mclk),
        .srst(srst),
        .launch(launch),
        .frame(frame),
        .frameLen(frameLen),
        .bitCycles(baud_q),
        .busy(txBusy),
        .lineOut(txLine)
    );

    assign txdOut = txLine;
    assign txdOe_n = !(txOwned_q && (!singleWire || ctrlOne_q.singleWireDirection));
    assign txPinOwned = txOwned_q;
    assign rxPinOwned = ctrlTwo_q.rxOn && !ctrlOne_q.loopbackSelect;

    // receiver input source
    always_comb begin
        if (!ctrlOne_q.loopbackSelect) begin
            rxLine = rxdIn;
        end else if (!ctrlOne_q.rxSourceSelect || ctrlOne_q.singleWireDirection) begin
            rxLine = txLine;
        end else begin
            rxLine = txdIn;
        end
    end

    // receiver: mid-bit sampling from the falling start edge
    always_ff @(posedge mclk) begin
        if (srst || !ctrlTwo_q.rxOn || baud_q == 16'h0000) begin
            rxState_q <= RX_IDLE;
            rxCyc_q <= 16'h0000;
            rxBit_q <= 4'h0;
            rxShift_q <= '0;
        end else begin
            unique case (rxState_q)
                RX_IDLE: begin
                    if (!rxLine) begin
                        rxState_q <= RX_START;
                        rxCyc_q <= {1'b0, baud_q[15:1]};
                    end
                end
                RX_START: begin
                    if (rxCyc_q != 16'h0000) begin
                        rxCyc_q <= rxCyc_q - 16'h0001;
                    end else if (rxLine) begin
                        rxState_q <= RX_IDLE;
                    end else begin
                        rxState_q <= RX_BITS;
                        rxCyc_q <= baud_q - 16'h0001;
                        rxBit_q <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (rxCyc_q != 16'h0000) begin
                        rxCyc_q <= rxCyc_q - 16'h0001;
                    end else begin
                        // new bit enters at the top, so the last data bit always lands in the msb
                        rxShift_q <= {rxLine, rxShift_q[UC2_WORD_W-1:1]};
                        rxCyc_q <= baud_q - 16'h0001;
                        rxBit_q <= rxBit_q + 4'h1;
                        if (rxBit_q == (ctrlOne_q.charLen9 ? UC2_DATA_BITS_LONG
                                : UC2_DATA_BITS_SHORT) - 4'h1) begin
                            rxState_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rxCyc_q != 16'h0000) begin
                        rxCyc_q <= rxCyc_q - 16'h0001;
                    end else begin
                        rxState_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    assign charDone = (rxState_q == RX_STOP) && (rxCyc_q == 16'h0000) && ctrlTwo_q.rxOn;
    assign wakeMark = charDone && ctrlTwo_q.rxStandby && ctrlOne_q.wakeOnMark
        && rxShift_q[UC2_WORD_W-1];
    // characters seen in standby are dropped unless they carry the wake mark
    assign deliver = charDone && (!ctrlTwo_q.rxStandby || wakeMark);

    always_ff @(posedge mclk) begin
        if (srst) begin
            rxData_q <= '0;
        end else if (deliver) begin
            rxData_q <= ctrlOne_q.charLen9 ? rxShift_q : {1'b0, rxShift_q[UC2_WORD_W-1:1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rxFull_q <= 1'b0;
        end else if (deliver) begin
            rxFull_q <= 1'b1;
        end else if (rdData) begin
            rxFull_q <= 1'b0;
        end
    end

    // idle line: a full character time of mark while the receiver waits for a start bit
    always_ff @(posedge mclk) begin
        if (srst || rxState_q != RX_IDLE || !rxLine || !ctrlTwo_q.rxOn) begin
            idleCyc_q <= 16'h0000;
            idleBits_q <= 4'h0;
        end else if (idleBits_q != char_bits(ctrlOne_q.charLen9)) begin
            if (idleCyc_q == baud_q - 16'h0001) begin
                idleCyc_q <= 16'h0000;
                idleBits_q <= idleBits_q + 4'h1;
            end else begin
                idleCyc_q <= idleCyc_q + 16'h0001;
            end
        end
    end

    assign idleHit = (idleBits_q == char_bits(ctrlOne_q.charLen9)) && !idleSeen_q;
    assign wakeIdle = idleHit && ctrlTwo_q.rxStandby && !ctrlOne_q.wakeOnMark;

    always_ff @(posedge mclk) begin
        if (srst) begin
            idleSeen_q <= 1'b0;
        end else if (idleBits_q != char_bits(ctrlOne_q.charLen9)) begin
            idleSeen_q <= 1'b0;
        end else begin
            idleSeen_q <= 1'b1;
        end
    end

    // flag reports once per burst of traffic, then waits for a new character
    always_ff @(posedge mclk) begin
        if (srst) begin
            idleArmed_q <= 1'b0;
        end else if (deliver) begin
            idleArmed_q <= 1'b1;
        end else if (idleHit && !ctrlTwo_q.rxStandby) begin
            idleArmed_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            lineQuiet_q <= 1'b0;
        end else if (idleHit && idleArmed_q && !ctrlTwo_q.rxStandby) begin
            lineQuiet_q <= 1'b1;
        end else if (rdData) begin
            lineQuiet_q <= 1'b0;
        end
    end

    // status and interrupt request
    assign status.txBufferEmptyFlag = !txFull_q;
    assign status.txDoneFlag = !txFull_q && !txBusy && !idleQueued_q && !breakQueued_q
        && !ctrlTwo_q.breakQueue;
    assign status.rxBufferFullFlag = rxFull_q;
    assign status.lineQuietFlag = lineQuiet_q;
    assign status.rxActive = (rxState_q != RX_IDLE);
    assign status.spare = 3'b000;

    assign irq = (ctrlTwo_q.txEmptyIrqEn && status.txBufferEmptyFlag)
        || (ctrlTwo_q.txDoneIrqEn && status.txDoneFlag)
        || (ctrlTwo_q.rxFullIrqEn && status.rxBufferFullFlag)
        || (ctrlTwo_q.lineQuietIrqEn && status.lineQuietFlag);
endmodule
`default_nettype wire

/* File: inc/uc2_pkg.sv */
// constants and carrier types for the serial control block
package uc2_pkg;
    // register byte addresses
    localparam logic [7:0] UC2_ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] UC2_ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] UC2_ADDR_STATUS = 8'h08;
    localparam logic [7:0] UC2_ADDR_DATA = 8'h0C;
    localparam logic [7:0] UC2_ADDR_BAUD = 8'h10;

    // reset values
    localparam logic [7:0] UC2_CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] UC2_CTRL_TWO_RESET = 8'h00;
    localparam logic [15:0] UC2_BAUD_RESET = 16'h0000;

    // frame and character lengths in bit times
    localparam logic [3:0] UC2_DATA_BITS_SHORT = 4'h8;
    localparam logic [3:0] UC2_DATA_BITS_LONG = 4'h9;
    localparam logic [3:0] UC2_CHAR_BITS_SHORT = 4'hA;
    localparam logic [3:0] UC2_CHAR_BITS_LONG = 4'hB;
    localparam logic [3:0] UC2_LONG_BREAK_EXTRA = 4'h3;
    localparam int UC2_FRAME_W = 14;
    localparam int UC2_WORD_W = 9;

    typedef struct packed {
        logic loopbackSelect;
        logic spare6;
        logic rxSourceSelect;
        logic charLen9;
        logic wakeOnMark;
        logic longBreakSelect;
        logic singleWireDirection;
        logic spare0;
    } uc2_ctrl_one_t;

    typedef struct packed {
        logic txEmptyIrqEn;
        logic txDoneIrqEn;
        logic rxFullIrqEn;
        logic lineQuietIrqEn;
        logic txOn;
        logic rxOn;
        logic rxStandby;
        logic breakQueue;
    } uc2_ctrl_two_t;

    typedef struct packed {
        logic txBufferEmptyFlag;
        logic txDoneFlag;
        logic rxBufferFullFlag;
        logic lineQuietFlag;
        logic rxActive;
        logic [2:0] spare;
    } uc2_status_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } uc2_wb_req_t;
endpackage

/* File: rtl/uc2_tx_shift.sv */
// transmit shifter: sends one frame of up to fourteen bits, lsb first
`timescale 1ns/100ps
`default_nettype none
module uc2_tx_shift (
    input wire logic mclk,
    input wire logic srst,
    input wire logic launch,
    input wire logic [uc2_pkg::UC2_FRAME_W-1:0] frame,
    input wire logic [3:0] frameLen,
    input wire logic [15:0] bitCycles,
    output logic busy,
    output logic lineOut
);
    import uc2_pkg::*;

    logic [UC2_FRAME_W-1:0] shift_q;
    logic [3:0] left_q;
    logic [15:0] cyc_q;
    logic busy_q;
    logic line_q;

    assign busy = busy_q;
    assign lineOut = line_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            busy_q <= 1'b0;
            line_q <= 1'b1;
            shift_q <= '0;
            left_q <= 4'h0;
            cyc_q <= 16'h0000;
        end else if (launch && !busy_q) begin
            busy_q <= 1'b1;
            shift_q <= frame;
            left_q <= frameLen;
            cyc_q <= bitCycles - 16'h0001;
            line_q <= frame[0];
        end else if (busy_q) begin
            if (cyc_q != 16'h0000) begin
                cyc_q <= cyc_q - 16'h0001;
            end else if (left_q == 4'h1) begin
                // line rests at mark once the frame is out
                busy_q <= 1'b0;
                line_q <= 1'b1;
            end else begin
                shift_q <= {1'b1, shift_q[UC2_FRAME_W-1:1]};
                line_q <= shift_q[1];
                left_q <= left_q - 4'h1;
                cyc_q <= bitCycles - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/uc2_checker.sv */
// port checks for the serial control core
`timescale 1ns/100ps
`default_nettype none
module uc2_checker (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input wire logic txdOut,
    input wire logic txdOe_n,
    input wire logic txPinOwned,
    input wire logic rxPinOwned,
    input wire logic irq
);
    import uc2_pkg::*;
    logic [7:0] ctrlOne_q;
    logic [7:0] ctrlTwo_q;
    wire logic req = cyc_i && stb_i && !ack_o;
    wire logic wr = req && we_i && sel_i[0];
    // shadows only; standby and break bits are ignored; hardware clears standby on wakeup
    always_ff @(posedge mclk) begin
        if (srst) ctrlOne_q <= UC2_CTRL_ONE_RESET;
        else if (wr && adr_i == UC2_ADDR_CTRL_ONE) ctrlOne_q <= dat_i[7:0];
    end
    always_ff @(posedge mclk) begin
        if (srst) ctrlTwo_q <= UC2_CTRL_TWO_RESET;
        else if (wr && adr_i == UC2_ADDR_CTRL_TWO) ctrlTwo_q <= dat_i[7:0];
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_ack_follows: assert property (req |=> ack_o)
        else $error("request not acked");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_unmapped_zero: assert property (req && !we_i && adr_i == 8'h14 |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (ctrlTwo_q[7:4] == 4'h0 |-> !irq)
        else $error("irq with all enables off");
    a_rx_pin: assert property (rxPinOwned == (ctrlTwo_q[2] && !ctrlOne_q[7]))
        else $error("receive pin ownership wrong");
    a_tx_owned: assert property (ctrlTwo_q[3] [*3] |-> txPinOwned)
        else $error("transmit pin not owned");
    a_oe_owned: assert property (!txPinOwned |-> txdOe_n && txdOut)
        else $error("pin driven or low while released");
    a_wire_rx: assert property (ctrlOne_q[7] && ctrlOne_q[5] && !ctrlOne_q[1] |-> txdOe_n)
        else $error("single wire receive still drives");
    a_tx_hold: assert property (!txdOut && txPinOwned |=> txPinOwned)
        else $error("pin released mid character");
    c_ctrl_write: cover property (wr && adr_i == UC2_ADDR_CTRL_TWO);
    c_irq: cover property (irq);
    c_hold: cover property (!txdOut && txPinOwned && !ctrlTwo_q[3]);
endmodule
`default_nettype wire

/* File: tb/uc2_remote_node.sv */
// remote serial node: drives the receive line, decodes the transmit pin
`timescale 1ns/100ps
`default_nettype none
module uc2_remote_node #(
    parameter int BAUD = 4
) (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd,
    output logic [8:0] got,
    output logic gotV
);
    logic [8:0] f;
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (BAUD) @(posedge mclk);
        end
    endtask
    // mid-bit sampling; a break decodes as zero data with a low stop
    initial begin
        gotV = 1'b0;
        got = 9'h000;
        forever begin
            @(posedge mclk);
            if (txd === 1'b0) begin
                repeat (BAUD / 2) @(posedge mclk);
                for (int i = 0; i < 9; i++) begin
                    repeat (BAUD) @(posedge mclk);
                    f[i] = txd;
                end
                got <= f;
                gotV <= 1'b1;
                @(posedge mclk);
                gotV <= 1'b0;
                for (int k = 0; k < 64 && txd !== 1'b1; k++) @(posedge mclk);
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/uart_control_two_tb_top.sv */
// bench for the serial control core with a remote node
`timescale 1ns/100ps
`default_nettype none
module uart_control_two_tb_top;
    import uc2_pkg::*;
    localparam int BAUD = 4;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic isRd = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] seed = 32'h8ECE;
    logic ack, txdOut, txdOe_n, txOwned, rxOwned, irq, gotV;
    logic [31:0] rdat;
    logic [8:0] got;
    wire logic rxd;
    wire logic txPin = txdOe_n ? 1'b1 : txdOut; // pull-up when released
    wire logic [1:0] watch = {irq, txdOut};
    int n_errors = 0;
    int comparisons = 0;
    logic [31:0] rdq[$];
    logic [31:0] txq[$];
    uc2_core u_dut (.mclk(mclk), .srst(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(sel), .adr_i(adr), .dat_i(dat), .ack_o(ack), .dat_o(rdat), .txdIn(txPin),
        .txdOut(txdOut), .txdOe_n(txdOe_n), .txPinOwned(txOwned), .rxdIn(rxd),
        .rxPinOwned(rxOwned), .irq(irq));
    uc2_remote_node #(.BAUD(BAUD)) u_node (.mclk(mclk), .txd(txPin), .rxd(rxd), .got(got),
        .gotV(gotV));
    initial forever #2.5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e);
        int n;
        @(posedge mclk);
        {cyc, stb, we, adr, dat, sel, isRd} <= {2'b11, w, a, d, 4'hF, !w};
        if (!w) rdq.push_back(e);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 32'h0);
    endtask
    task automatic waitOn(input int b, input logic v);
        for (int k = 0; k < 400 && watch[b] !== v; k++) @(posedge mclk);
        if (watch[b] !== v) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic waitq;
        for (int k = 0; k < 400 && txq.size() > 0; k++) @(posedge mclk);
        if (txq.size() > 0) begin
            n_errors++;
            end_of_test();
        end
    endtask
    // read data and decoded frames are matched against the oldest note
    always @(posedge mclk) begin
        if (ack === 1'b1 && isRd) chk(rdat, rdq.pop_front());
        if (gotV === 1'b1) chk({23'h0, got}, txq.size() ? txq.pop_front() : 32'hFFFFFFFF);
    end
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        wb(1'b0, UC2_ADDR_CTRL_TWO, 32'h0, {24'h0, UC2_CTRL_TWO_RESET});
        wb(1'b0, UC2_ADDR_STATUS, 32'h0, 32'hC0);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr(UC2_ADDR_CTRL_TWO, {24'h0, seed[7:4], 4'h0});
            chk({31'h0, irq}, {31'h0, seed[7] | seed[6]});
            wb(1'b0, UC2_ADDR_CTRL_TWO, 32'h0, {24'h0, seed[7:4], 4'h0});
        end
        wb(1'b0, 8'h14, 32'h0, 32'h0);
        wr(UC2_ADDR_BAUD, 32'(BAUD));
        wr(UC2_ADDR_CTRL_TWO, 32'h48);
        seed = xs(seed);
        txq.push_back({23'h1, seed[7:0]});
        wr(UC2_ADDR_DATA, {24'h0, seed[7:0]});
        waitOn(0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        // transmitter off mid character, then back on to queue an idle
        wr(UC2_ADDR_CTRL_TWO, 32'h40);
        wr(UC2_ADDR_CTRL_TWO, 32'h48);
        txq.push_back(32'h15A);
        wr(UC2_ADDR_DATA, 32'h5A);
        waitq();
        wr(UC2_ADDR_CTRL_TWO, 32'h09);
        wr(UC2_ADDR_CTRL_TWO, 32'h08);
        txq.push_back(32'h0);
        waitq();
        wr(UC2_ADDR_CTRL_ONE, 32'hA0);
        chk({31'h0, txdOe_n}, 32'h1);
        wr(UC2_ADDR_CTRL_ONE, 32'hA2);
        chk({31'h0, txdOe_n}, 32'h0);
        wr(UC2_ADDR_CTRL_TWO, 32'h0C);
        chk({31'h0, rxOwned}, 32'h0);
        wr(UC2_ADDR_CTRL_ONE, 32'h00);
        chk({31'h0, rxOwned}, 32'h1);
        wr(UC2_ADDR_CTRL_TWO, 32'h2C);
        u_node.send(8'h3C);
        waitOn(1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, UC2_ADDR_DATA, 32'h0, 32'h3C);
        chk({31'h0, irq}, 32'h0);
        // a quiet character time after that character raises the idle flag
        wr(UC2_ADDR_CTRL_TWO, 32'h1C);
        waitOn(1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, UC2_ADDR_DATA, 32'h0, 32'h3C);
        chk({31'h0, irq}, 32'h0);
        wr(UC2_ADDR_CTRL_ONE, 32'h08);
        wr(UC2_ADDR_CTRL_TWO, 32'h2E);
        u_node.send(8'h15);
        wb(1'b0, UC2_ADDR_CTRL_TWO, 32'h0, 32'h2E);
        chk({31'h0, irq}, 32'h0);
        u_node.send(8'h95);
        wb(1'b0, UC2_ADDR_CTRL_TWO, 32'h0, 32'h2C);
        wb(1'b0, UC2_ADDR_DATA, 32'h0, 32'h95);
        waitq();
        end_of_test();
    end
endmodule
bind uc2_core uc2_checker u_chk (.mclk, .srst, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i,
    .ack_o, .dat_o, .txdOut, .txdOe_n, .txPinOwned, .rxPinOwned, .irq);
`default_nettype wire
